// File: logic/psbi_bus_if.sv
// Processor side of the multiplexed system bus with its write buffer
`timescale 1ns/1ns
`default_nettype none
`include "psbi_defs.svh"
module psbi_bus_if
	import psbi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire psbi_entry_t wr_entry,
	input wire logic rd_req,
	input wire logic [63:0] rd_addr,
	input wire logic rd_block,
	input wire logic [2:0] rd_size,
	output logic rd_ack,
	output logic [63:0] rd_data,
	output logic rd_data_valid,
	output logic rd_last,
	output logic rd_error,
	output logic ext_wr_valid,
	output logic [63:0] ext_wr_addr,
	output logic [63:0] ext_wr_data,
	input wire logic [1:0] write_mode,
	input wire logic [3:0] data_rate,
	input wire logic [63:0] ad_i,
	output logic [63:0] ad_o,
	output logic ad_oe,
	input wire logic [7:0] check_i,
	output logic [7:0] check_o,
	output logic check_oe,
	input wire logic [8:0] cmd_i,
	output logic [8:0] cmd_o,
	output logic cmd_oe,
	output logic proc_valid_n,
	input wire logic agent_valid_n,
	input wire logic read_accept_n,
	input wire logic write_accept_n,
	input wire logic agent_bus_request_n,
	output logic release_n
);
	localparam int SW = 91;
	// Even parity per byte lane
	function automatic logic [7:0] parity(input logic [63:0] d);
		logic [7:0] p;
		p = '0;
		for (int i = 0; i < 8; i++)
			p[i] = ^d[8*i +: 8];
		return p;
	endfunction
	psbi_state_t state;
	psbi_state_t next_state;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [63:0] s_ad;
	logic [7:0] s_check;
	logic [8:0] s_cmd;
	logic s_avalid_n;
	logic s_racc_n;
	logic s_wacc_n;
	logic s_req_n;
	logic [1:0] s_mode;
	logic [3:0] s_rate;
	logic acc_p1;
	logic acc_p2;
	logic acc_ok;
	psbi_entry_t head;
	logic head_valid;
	logic pop;
	logic [63:0] next_ad;
	logic [8:0] next_cmd;
	logic next_oe;
	logic next_valid_n;
	logic next_release_n;
	logic [1:0] gap;
	logic [1:0] next_gap;
	logic pair;
	logic sent_last;
	logic ext_have_addr;
	logic agent_word;
	logic agent_last;
	// Two-flop synchroniser for every pin input
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			sync1 <= '1;
			sync2 <= '1;
		end
		else
		begin
			sync1 <= {ad_i, check_i, cmd_i, agent_valid_n, read_accept_n, write_accept_n,
				agent_bus_request_n, write_mode, data_rate};
			sync2 <= sync1;
		end
	end
	assign {s_ad, s_check, s_cmd, s_avalid_n, s_racc_n, s_wacc_n, s_req_n, s_mode, s_rate} = sync2;
	assign agent_word = !s_avalid_n;
	// Final data word, whether or not it also carries the error flag
	assign agent_last = agent_word && ((s_cmd & ~`PSBI_CMD_ERROR) == `PSBI_DATA_LAST_CMD);
	// Outbound write buffer; the core only stalls when it is full
	psbi_fifo #(.W($bits(psbi_entry_t)), .DEPTH(`PSBI_WBUF_DEPTH)) u_wbuf (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_entry),
		.out_valid(head_valid),
		.out_ready(pop),
		.out_data(head)
	);
	// Write accept history for the enhanced write modes
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			acc_p1 <= 1'b0;
			acc_p2 <= 1'b0;
		end
		else
		begin
			acc_p1 <= !s_wacc_n;
			acc_p2 <= acc_p1;
		end
	end
	// Issue condition of a write address cycle
	always_comb
	begin
		acc_ok = !s_wacc_n;
		if (!head.block && s_mode == `PSBI_WMODE_REISSUE)
			acc_ok = !s_wacc_n && acc_p2;
		else if (!head.block && s_mode == `PSBI_WMODE_PIPE)
			acc_ok = !s_wacc_n || acc_p1;
	end
	// Next state and next bus drive
	always_comb
	begin
		next_state = state;
		next_ad = ad_o;
		next_cmd = cmd_o;
		next_oe = ad_oe;
		next_valid_n = 1'b1;
		next_release_n = 1'b1;
		next_gap = gap;
		pop = 1'b0;
		rd_ack = 1'b0;
		unique case (state)
			ST_IDLE:
			begin
				next_oe = 1'b0;
				if (!s_req_n)
				begin
					next_release_n = 1'b0;
					next_state = ST_SLAVE;
				end
				else if (head_valid)
				begin
					// Writes drain before any read is issued
					next_ad = head.addr;
					next_cmd = `PSBI_CMD_WRITE | (head.block ? `PSBI_CMD_BLOCK : 9'h000) |
						{6'h00, head.size};
					next_oe = 1'b1;
					next_valid_n = 1'b0;
					next_state = ST_WADDR;
				end
				else if (rd_req)
				begin
					rd_ack = 1'b1;
					next_ad = rd_addr;
					next_cmd = `PSBI_CMD_READ | (rd_block ? `PSBI_CMD_BLOCK : 9'h000) |
						{6'h00, rd_size};
					next_oe = 1'b1;
					next_valid_n = 1'b0;
					next_state = ST_RADDR;
				end
			end
			ST_RADDR:
			begin
				if (!s_racc_n)
				begin
					next_oe = 1'b0;
					next_release_n = 1'b0;
					next_state = ST_RWAIT;
				end
				else
					next_valid_n = 1'b0;
			end
			ST_RWAIT:
			begin
				next_oe = 1'b0;
				if (agent_last)
					next_state = ST_IDLE;
			end
			ST_WADDR:
			begin
				if (acc_ok)
				begin
					pop = 1'b1;
					next_ad = head.data;
					next_cmd = head.last ? `PSBI_DATA_LAST_CMD : `PSBI_DATA_NOT_LAST_CMD;
					next_state = ST_WDATA;
				end
				next_valid_n = 1'b0; // address redriven while not issued
			end
			ST_WDATA:
			begin
				if (sent_last)
				begin
					next_oe = 1'b0;
					next_state = ST_IDLE;
				end
				else if (gap != 2'h0)
					next_gap = gap - 2'h1;
				else if (pair && s_rate == `PSBI_RATE_DDXX && !proc_valid_n)
					next_gap = `PSBI_GAP_CYCLES - 2'h1;
				else if (head_valid)
				begin
					pop = 1'b1;
					next_ad = head.data;
					next_cmd = head.last ? `PSBI_DATA_LAST_CMD : `PSBI_DATA_NOT_LAST_CMD;
					next_valid_n = 1'b0;
				end
			end
			ST_SLAVE:
			begin
				next_oe = 1'b0;
				if (agent_word && s_cmd == `PSBI_CMD_NULL)
					next_state = ST_IDLE;
			end
		endcase
	end
	// Controller state
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end
	// Registered bus drive with parity
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ad_o <= '0;
			cmd_o <= '0;
			check_o <= '0;
			ad_oe <= 1'b0;
			check_oe <= 1'b0;
			cmd_oe <= 1'b0;
			proc_valid_n <= 1'b1;
			release_n <= 1'b1;
		end
		else
		begin
			ad_o <= next_ad;
			cmd_o <= next_cmd;
			check_o <= parity(next_ad);
			ad_oe <= next_oe;
			check_oe <= next_oe;
			cmd_oe <= next_oe;
			proc_valid_n <= next_valid_n;
			release_n <= next_release_n;
		end
	end
	// Data pattern pacing and end-of-write tracking
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			gap <= 2'h0;
			pair <= 1'b0;
			sent_last <= 1'b0;
		end
		else
		begin
			gap <= next_gap;
			if (state != ST_WADDR && state != ST_WDATA)
				pair <= 1'b0;
			else if (pop)
				pair <= (state == ST_WDATA) ? !pair : 1'b0;
			sent_last <= pop && head.last;
		end
	end
	// Inbound read data, paced solely by agent valid
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rd_data <= '0;
			rd_data_valid <= 1'b0;
			rd_last <= 1'b0;
			rd_error <= 1'b0;
		end
		else
		begin
			rd_data_valid <= (state == ST_RWAIT) && agent_word && s_cmd[8];
			rd_last <= (state == ST_RWAIT) && agent_last;
			if ((state == ST_RWAIT) && agent_word)
			begin
				rd_data <= s_ad;
				rd_error <= ((s_cmd & `PSBI_CMD_ERROR) != 9'h000) || (s_check != parity(s_ad));
			end
		end
	end
	// External write requests update the writable resource
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ext_have_addr <= 1'b0;
			ext_wr_valid <= 1'b0;
			ext_wr_addr <= '0;
			ext_wr_data <= '0;
		end
		else
		begin
			ext_wr_valid <= 1'b0;
			if (state != ST_SLAVE)
				ext_have_addr <= 1'b0;
			else if (agent_word && (s_cmd & `PSBI_CMD_TYPE_MASK) == `PSBI_CMD_WRITE)
			begin
				ext_have_addr <= 1'b1;
				ext_wr_addr <= s_ad;
			end
			else if (agent_word && s_cmd[8] && ext_have_addr)
			begin
				ext_have_addr <= 1'b0;
				ext_wr_valid <= 1'b1;
				ext_wr_data <= s_ad;
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_VALID_DRIVES: assert property (!proc_valid_n |-> ad_oe && cmd_oe)
		else $error("valid asserted without driving");
	AST_PARITY: assert property (ad_oe |-> check_o == parity(ad_o))
		else $error("check bits wrong");
	AST_REQ_RELEASE: assert property (state == ST_IDLE && !s_req_n |=> !release_n ##1 !ad_oe)
		else $error("bus request not released");
	AST_READ_RELEASE: assert property (state == ST_RADDR && !s_racc_n |=> !release_n && !ad_oe)
		else $error("read not released on accept");
	AST_SLAVE_QUIET: assert property (state == ST_SLAVE |-> !ad_oe && proc_valid_n)
		else $error("drive in slave state");
	AST_NULL_RETURN: assert property (state == ST_SLAVE && agent_word && s_cmd == `PSBI_CMD_NULL
		|=> state == ST_IDLE)
		else $error("null did not return bus");
	AST_REISSUE: assert property (state == ST_WADDR && !head.block && s_mode == `PSBI_WMODE_REISSUE
		&& !(acc_p2 && !s_wacc_n) |=> state == ST_WADDR && !proc_valid_n)
		else $error("write issued without accept history");
	AST_LAST_ENDS: assert property (state == ST_WDATA && !proc_valid_n && cmd_o == `PSBI_DATA_LAST_CMD
		|=> !ad_oe && state == ST_IDLE)
		else $error("write did not end after last word");
	AST_GAP: assert property ($rose(pair) && state == ST_WDATA && s_rate == `PSBI_RATE_DDXX && !sent_last
		|=> proc_valid_n [*2])
		else $error("idle pair missing");
	AST_EXT_WRITE: assert property (state == ST_SLAVE && ext_have_addr && agent_word && s_cmd[8]
		|=> ext_wr_valid && ext_wr_data == $past(s_ad))
		else $error("external write lost");
	COV_BLOCK_WRITE: cover property (state == ST_WDATA && cmd_o == `PSBI_DATA_LAST_CMD && pair);
	COV_READ: cover property (rd_data_valid && rd_last);
	COV_EXT_WRITE: cover property (ext_wr_valid);
	COV_NULL: cover property (state == ST_SLAVE ##1 state == ST_IDLE);
endmodule
`default_nettype wire

// File: logic/psbi_defs.svh
// Constants of the processor system bus interface
`ifndef PSBI_DEFS_SVH
`define PSBI_DEFS_SVH
// Command bus codes, address cycles
`define PSBI_CMD_READ 9'h000
`define PSBI_CMD_WRITE 9'h040
`define PSBI_CMD_NULL 9'h060
`define PSBI_CMD_BLOCK 9'h008
`define PSBI_CMD_TYPE_MASK 9'h1e0
`define PSBI_CMD_SIZE_MASK 9'h007
// Command bus codes, data cycles
`define PSBI_CMD_DATA 9'h100
`define PSBI_DATA_LAST_CMD 9'h100
`define PSBI_DATA_NOT_LAST_CMD 9'h180
`define PSBI_CMD_ERROR 9'h020
// Non-block write modes
`define PSBI_WMODE_LEGACY 2'h0
`define PSBI_WMODE_PIPE 2'h2
`define PSBI_WMODE_REISSUE 2'h3
// Write data pattern with two idle cycles after each pair
`define PSBI_RATE_DDXX 4'h2
`define PSBI_GAP_CYCLES 2'h2
// Doublewords of a block and entries of the write buffer
`define PSBI_BLOCK_WORDS 4
`define PSBI_WBUF_DEPTH 4
`endif

// File: logic/psbi_pkg.sv
// Types shared by the processor system bus interface
package psbi_pkg;
	// One write buffer entry: address, data and transfer shape
	typedef struct packed {
		logic [63:0] addr;
		logic [63:0] data;
		logic block;
		logic last;
		logic [2:0] size;
	} psbi_entry_t;
	// Bus controller states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RADDR = 6'h02,
		ST_RWAIT = 6'h04,
		ST_WADDR = 6'h08,
		ST_WDATA = 6'h10,
		ST_SLAVE = 6'h20
	} psbi_state_t;
endpackage

// File: logic/psbi_fifo.sv
// Parameterised FIFO used as the outbound write buffer
`timescale 1ns/1ns
`default_nettype none
module psbi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// Refuse depths the pointer logic cannot serve
	if (DEPTH < 2 || W < 1)
	begin : g_bad
		$error("psbi_fifo: DEPTH must be at least 2");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;
	// Handshakes and head of queue
	assign in_ready = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end
	// Pointers and fill count
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end
		else
		begin
			if (push)
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: verif/psbi_agent.sv
// Behavioural system agent on the far side of the processor bus
`timescale 1ns/1ns
`default_nettype none
`include "psbi_defs.svh"
module psbi_agent
	import psbi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [63:0] ad_o,
	input wire logic ad_oe,
	input wire logic [7:0] check_o,
	input wire logic check_oe,
	input wire logic [8:0] cmd_o,
	input wire logic cmd_oe,
	input wire logic proc_valid_n,
	input wire logic release_n,
	output logic [63:0] ad_i,
	output logic [7:0] check_i,
	output logic [8:0] cmd_i,
	output var logic agent_valid_n,
	output var logic read_accept_n,
	output var logic write_accept_n,
	output var logic agent_bus_request_n
);
	logic drv = 1'h0;
	logic [63:0] drv_ad = 64'h0;
	logic [8:0] drv_cmd = 9'h0;
	logic [63:0] flt = 64'h0f0f_0f0f_0f0f_0f0f;
	logic [64:0] pa = 65'h0;
	logic [63:0] ca = 64'h0;
	logic [8:0] cw = 9'h0;
	logic pend = 1'h0;
	logic slow = 1'h0;
	logic own = 1'h0;
	int err_at = -1;
	int perr = 0;
	int cyc = 0;
	int rn;
	logic [63:0] qa[$];
	logic [63:0] qd[$];
	logic [8:0] qc[$];
	logic [8:0] qw[$];
	int qt[$];

	// Even parity per byte
	function automatic logic [7:0] par(input logic [63:0] x);
		for (int i = 0; i < 8; i++)
			par[i] = ^x[8*i +: 8];
	endfunction

	// Wire levels: processor first, then agent, else a toggling pattern
	assign ad_i = ad_oe ? ad_o : drv ? drv_ad : flt;
	assign check_i = check_oe ? check_o : drv ? par(drv_ad) : flt[7:0];
	assign cmd_i = cmd_oe ? cmd_o : drv ? drv_cmd : flt[8:0];

	// Handshakes idle, both kinds of request accepted
	initial
	begin
		agent_valid_n = 1'h1;
		read_accept_n = 1'h0;
		write_accept_n = 1'h0;
		agent_bus_request_n = 1'h1;
	end

	// Log processor cycles, check their parity, note read requests
	always @(posedge sys_clk)
	begin
		flt <= ~flt;
		cyc <= cyc + 1;
		if (!proc_valid_n && cmd_oe)
		begin
			if (check_o !== par(ad_o))
				perr <= perr + 1;
			if (cmd_o[8])
			begin
				qa.push_back(ca);
				qd.push_back(ad_o);
				qc.push_back(cmd_o);
				qw.push_back(cw);
				qt.push_back(cyc);
			end
			else if (cmd_o[8:5] == 4'h0)
			begin
				pa <= {cmd_o[3], ad_o};
				pend <= 1'h1;
			end
			else
			begin
				ca <= ad_o;
				cw <= cmd_o;
			end
		end
	end

	// Drive one valid word for one cycle
	task automatic word(input logic [63:0] a, input logic [8:0] c);
		drv = 1'h1;
		drv_ad = a;
		drv_cmd = c;
		agent_valid_n = 1'h0;
		@(posedge sys_clk);
		#10;
	endtask

	// Hold the bus with nothing valid on it
	task automatic idle();
		agent_valid_n = 1'h1;
		drv_ad = ~drv_ad;
		@(posedge sys_clk);
		#10;
	endtask

	// Answer a pending read once the bus is released, at a pace of our own
	always
	begin
		@(posedge sys_clk);
		#10;
		if (pend && !release_n)
		begin
			pend = 1'h0;
			rn = pa[64] ? 4 : 1;
			for (int i = 0; i < rn; i++)
			begin
				word(pa[63:0] + i, (i == rn - 1 ? `PSBI_DATA_LAST_CMD : `PSBI_DATA_NOT_LAST_CMD)
					| (i == err_at ? `PSBI_CMD_ERROR : 9'h000));
				if (slow)
					idle();
			end
			agent_valid_n = 1'h1;
			drv = 1'h0;
		end
	end

	// Take the bus, then send a write or a null request
	task automatic ext_req(input logic nul, input logic [63:0] a, input logic [63:0] d);
		// Ask for the bus only when it is not ours already
		if (!own)
		begin
			agent_bus_request_n = 1'h0;
			@(negedge release_n);
			#10;
			agent_bus_request_n = 1'h1;
			own = 1'h1;
		end
		word(a, nul ? `PSBI_CMD_NULL : `PSBI_CMD_WRITE);
		if (!nul)
			word(d, `PSBI_DATA_LAST_CMD);
		else
			own = 1'h0;
		agent_valid_n = 1'h1;
		drv = 1'h0;
	endtask
endmodule
`default_nettype wire

// File: verif/tb_processor_system_bus_interface.sv
// Self-checking bench of the processor bus interface
`timescale 1ns/1ns
`default_nettype none
`include "psbi_defs.svh"
module tb_processor_system_bus_interface
	import psbi_pkg::*;
;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic wr_valid = 1'h0;
	psbi_entry_t wr_entry = 0;
	logic rd_req = 1'h0;
	logic [63:0] rd_addr = 64'h0;
	logic rd_block = 1'h0;
	logic [2:0] rd_size = 3'h0;
	logic [1:0] write_mode = 2'h0;
	logic [3:0] data_rate = 4'h0;
	logic wr_ready, rd_ack, rd_data_valid, rd_last, rd_error, ext_wr_valid, ad_oe, check_oe, cmd_oe;
	logic proc_valid_n, agent_valid_n, read_accept_n, write_accept_n, agent_bus_request_n, release_n;
	logic [63:0] rd_data, ext_wr_addr, ext_wr_data, ad_i, ad_o;
	logic [7:0] check_i, check_o;
	logic [8:0] cmd_i, cmd_o;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc_count = 0;

	psbi_bus_if i_dut (.sys_clk, .sys_rst, .wr_valid, .wr_ready, .wr_entry, .rd_req, .rd_addr, .rd_block,
		.rd_size, .rd_ack, .rd_data, .rd_data_valid, .rd_last, .rd_error, .ext_wr_valid, .ext_wr_addr,
		.ext_wr_data, .write_mode, .data_rate, .ad_i, .ad_o, .ad_oe, .check_i, .check_o, .check_oe, .cmd_i,
		.cmd_o, .cmd_oe, .proc_valid_n, .agent_valid_n, .read_accept_n, .write_accept_n,
		.agent_bus_request_n, .release_n);
	psbi_agent i_agent (.sys_clk, .ad_o, .ad_oe, .check_o, .check_oe, .cmd_o, .cmd_oe, .proc_valid_n,
		.release_n, .ad_i, .check_i, .cmd_i, .agent_valid_n, .read_accept_n, .write_accept_n,
		.agent_bus_request_n);

	// Clock at 100 ns period
	always #50 sys_clk = ~sys_clk;

	// Print the verdict and stop
	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge sys_clk)
	begin
		cyc_count++;
		if (cyc_count == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	// Compare and count
	task automatic chk(input logic [128:0] got, input logic [128:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask

	// Wait edges, then step past them
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#10;
	endtask

	// Offer one buffer entry until it is taken; valid stays up
	task automatic push(input logic [63:0] a, input logic [63:0] d, input logic b, input logic l,
		input logic [2:0] s);
		wr_valid = 1'h1;
		wr_entry = '{a, d, b, l, s};
		for (int i = 0; i < 300 && !wr_ready; i++)
			tick(1);
		tick(1);
	endtask

	// Wait until the agent has logged k data words
	task automatic drain(input int k);
		for (int i = 0; i < 300 && i_agent.qd.size() < k; i++)
			tick(1);
		chk(i_agent.qd.size(), k, "write count");
	endtask

	// Check the oldest logged write word
	task automatic wchk(input logic [63:0] a, input logic [63:0] d, input logic [8:0] ac,
		input logic [8:0] dc, output int t);
		chk(i_agent.qa.pop_front(), a, "write address");
		chk(i_agent.qd.pop_front(), d, "write data");
		chk({i_agent.qw.pop_front() & 9'h1ef, i_agent.qc.pop_front()}, {ac, dc}, "write commands");
		t = i_agent.qt.pop_front();
	endtask

	// Issue a read and check every returned word with its flags
	task automatic do_read(input logic [63:0] a, input logic b, input int e);
		int k;
		k = 0;
		rd_addr = a;
		rd_block = b;
		rd_size = b ? 3'h0 : 3'h7;
		rd_req = 1'h1;
		i_agent.err_at = e;
		// Let the acknowledge settle on the new request before looking at it
		#1;
		for (int i = 0; i < 300 && !rd_ack; i++)
			tick(1);
		tick(1);
		rd_req = 1'h0;
		for (int i = 0; i < 300 && k < (b ? 4 : 1); i++)
		begin
			if (rd_data_valid === 1'h1)
			begin
				chk({rd_data, rd_last, rd_error}, {a + k, k == (b ? 3 : 0), k == e}, "read word");
				k++;
			end
			tick(1);
		end
		chk(k, b ? 4 : 1, "read count");
	endtask

	// One non-block write in every mode, each with its own size and byte lane
	task automatic s_modes();
		int t;
		for (int m = 0; m < 4; m++)
		begin
			write_mode = m[1:0];
			i_agent.write_accept_n = 1'h1;
			tick(4);
			push(64'h1000 + m, 64'h5a00 + m, 1'h0, 1'h1, m[2:0] + 3'h1);
			wr_valid = 1'h0;
			tick(6);
			chk(i_agent.qd.size(), 0, "write issued without accept");
			i_agent.write_accept_n = 1'h0;
			drain(1);
			wchk(64'h1000 + m, 64'h5a00 + m, `PSBI_CMD_WRITE | (m + 1), `PSBI_DATA_LAST_CMD, t);
		end
	endtask

	// Line writeback fills the buffer; a read waits behind it; writes go out as two words, two idle
	task automatic s_block();
		int t[4];
		data_rate = `PSBI_RATE_DDXX;
		i_agent.write_accept_n = 1'h1;
		tick(4);
		for (int i = 0; i < 4; i++)
			push(64'h2000 + 8 * i, 64'hb0 + i, 1'h1, i == 3, 3'h0);
		wr_valid = 1'h0;
		chk(wr_ready, 1'h0, "buffer full");
		rd_req = 1'h1;
		for (int i = 0; i < 6; i++)
		begin
			chk(rd_ack, 1'h0, "read while writes pending");
			tick(1);
		end
		i_agent.write_accept_n = 1'h0;
		do_read(64'h4000, 1'h1, -1);
		drain(4);
		for (int i = 0; i < 4; i++)
			wchk(64'h2000, 64'hb0 + i, `PSBI_CMD_WRITE | `PSBI_CMD_BLOCK,
				i == 3 ? `PSBI_DATA_LAST_CMD : `PSBI_DATA_NOT_LAST_CMD, t[i]);
		chk((t[1] - t[0]) * 100 + (t[2] - t[1]) * 10 + t[3] - t[2], 131, "block pattern");
	endtask

	// Agent takes the bus, writes a resource, then hands the bus back
	task automatic s_ext();
		int t;
		i_agent.ext_req(1'h0, 64'h3000, 64'h77);
		chk({ad_oe, cmd_oe, proc_valid_n}, 3'h1, "slave drivers off");
		for (int i = 0; i < 20 && ext_wr_valid !== 1'h1; i++)
			tick(1);
		chk({ext_wr_valid, ext_wr_addr, ext_wr_data}, {1'h1, 64'h3000, 64'h77}, "agent write");
		i_agent.ext_req(1'h1, 64'h0, 64'h0);
		push(64'h5000, 64'h99, 1'h0, 1'h1, 3'h7);
		wr_valid = 1'h0;
		drain(1);
		wchk(64'h5000, 64'h99, `PSBI_CMD_WRITE | 9'h007, `PSBI_DATA_LAST_CMD, t);
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#10;
		sys_rst = 1'h0;
		tick(1);
		chk({ad_oe, cmd_oe, check_oe, proc_valid_n, release_n, wr_ready, rd_ack}, 7'h0e, "reset state");
		s_modes();
		s_block();
		i_agent.slow = 1'h1;
		do_read(64'h4008, 1'h0, 0);
		i_agent.slow = 1'h0;
		s_ext();
		chk(i_agent.perr, 0, "check bits");
		tally_and_finish();
	end
endmodule
`default_nettype wire
